// ---- hdl/pat_pkg.sv ----
// Package for the protection alarm and trip aggregator
// Assumes a 32-bit APB register bus and one system clock
package pat_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PAT_OFF_CTRL = 8'h00;
    localparam logic [7:0] PAT_OFF_SUPV = 8'h04;
    localparam logic [7:0] PAT_OFF_ONEP = 8'h08;
    localparam logic [7:0] PAT_OFF_DLY = 8'h0C;
    localparam logic [7:0] PAT_OFF_STAT = 8'h10;
    localparam logic [7:0] PAT_OFF_ELEM = 8'h14;
    localparam logic [7:0] PAT_OFF_IRQ = 8'h18;
    localparam logic [7:0] PAT_OFF_MASK = 8'h1C;
    localparam logic [7:0] PAT_OFF_CBA = 8'h20;
    localparam logic [7:0] PAT_OFF_CBB = 8'h24;
    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int PAT_CTRL_FUNC = 0;
    localparam int PAT_CTRL_EXBA = 1;
    localparam int PAT_CTRL_PERM = 2;
    localparam int PAT_CTRL_EXTA = 3;
    localparam int PAT_CTRL_BLKM = 4;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [4:0] PAT_CTRL_RST = 5'h01;
    localparam logic [15:0] PAT_DLY_RST = 16'h0004;
    // Interrupt bits: general alarm rise, general trip rise, trip command rise
    localparam int PAT_IRQ_W = 3;
endpackage

// ---- hdl/pat_aggregator.sv ----
// Protection alarm and trip aggregator with APB register access
// Assumes synchronous element criteria and block inputs on i_clock
`timescale 1ns/10ps
module pat_aggregator
    import pat_pkg::*;
#(
    parameter int N_ELEM = 8,
    parameter int DLY_W = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [N_ELEM-1:0] i_fault_crit,
    input wire logic [N_ELEM-1:0] i_fault_ph_a,
    input wire logic [N_ELEM-1:0] i_fault_ph_b,
    input wire logic [N_ELEM-1:0] i_fault_ph_c,
    input wire logic i_ext_block_input_a,
    input wire logic i_ext_block_input_b,
    input wire logic i_ext_trip_cmd_block_input,
    input wire logic [N_ELEM-1:0] i_elem_cmd_block,
    output logic [N_ELEM-1:0] o_elem_alarm,
    output logic [N_ELEM-1:0] o_elem_trip,
    output logic [N_ELEM-1:0] o_trip_command_out,
    output logic o_general_alarm,
    output logic o_general_trip,
    output logic o_phase_a_collective_alarm,
    output logic o_phase_b_collective_alarm,
    output logic o_phase_c_collective_alarm,
    output logic o_phase_a_collective_trip,
    output logic o_phase_b_collective_trip,
    output logic o_phase_c_collective_trip,
    output logic o_cb_a_trip,
    output logic o_cb_b_trip,
    output logic o_irq
);
    initial begin
        if (N_ELEM < 1 || N_ELEM > 32) $error("N_ELEM must be 1 to 32");
        if (DLY_W < 1 || DLY_W > 16) $error("DLY_W must be 1 to 16");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [4:0] ctrl_r;
    logic [N_ELEM-1:0] supv_r;
    logic [N_ELEM-1:0] onep_r;
    logic [DLY_W-1:0] dly_r;
    logic [N_ELEM-1:0] cba_r;
    logic [N_ELEM-1:0] cbb_r;
    logic [PAT_IRQ_W-1:0] irq_stat_r;
    logic [PAT_IRQ_W-1:0] irq_mask_r;
    logic [N_ELEM-1:0] crit_r;
    logic [N_ELEM-1:0] pha_r;
    logic [N_ELEM-1:0] phb_r;
    logic [N_ELEM-1:0] phc_r;
    logic [N_ELEM-1:0] eblk_r;
    logic exa_r;
    logic exb_r;
    logic ext_r;
    logic [DLY_W-1:0] tmr_r [N_ELEM];
    logic [N_ELEM-1:0] trip_st;
    logic [N_ELEM-1:0] alarm_st;
    logic prot_block;
    logic cmd_block;
    logic [N_ELEM-1:0] contrib;
    logic [N_ELEM-1:0] cmd_nxt;
    logic [PAT_IRQ_W-1:0] irq_ev;
    logic [PAT_IRQ_W-1:0] irq_clr;
    logic wr_en;
    logic rd_en;

    function automatic logic [31:0] pad(input logic [N_ELEM-1:0] v);
        pad = 32'h0000_0000;
        pad[N_ELEM-1:0] = v;
    endfunction

    // ----------------------------------------------------------------
    // Input sampling
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            crit_r <= '0;
            pha_r <= '0;
            phb_r <= '0;
            phc_r <= '0;
            eblk_r <= '0;
            exa_r <= 1'b0;
            exb_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            crit_r <= i_fault_crit;
            pha_r <= i_fault_ph_a;
            phb_r <= i_fault_ph_b;
            phc_r <= i_fault_ph_c;
            eblk_r <= i_elem_cmd_block;
            exa_r <= i_ext_block_input_a;
            exb_r <= i_ext_block_input_b;
            ext_r <= i_ext_trip_cmd_block_input;
        end
    end

    // ----------------------------------------------------------------
    // Blocking
    // ----------------------------------------------------------------
    always_comb begin
        prot_block = !ctrl_r[PAT_CTRL_FUNC] || ctrl_r[PAT_CTRL_BLKM];
        if (ctrl_r[PAT_CTRL_EXBA] && (exa_r || exb_r)) begin
            prot_block = 1'b1;
        end
        cmd_block = ctrl_r[PAT_CTRL_PERM]
            || (ctrl_r[PAT_CTRL_EXTA] && ext_r);
    end

    // ----------------------------------------------------------------
    // Element alarm and delayed trip
    // ----------------------------------------------------------------
    always_comb begin
        alarm_st = prot_block ? '0 : crit_r;
        for (int i = 0; i < N_ELEM; i++) begin
            trip_st[i] = alarm_st[i] && (tmr_r[i] >= dly_r);
        end
        contrib = ~supv_r;
        cmd_nxt = trip_st & contrib & ~eblk_r & {N_ELEM{!cmd_block}};
    end

    always_ff @(posedge i_clock) begin
        for (int i = 0; i < N_ELEM; i++) begin
            if (!i_rst_n || !alarm_st[i]) begin
                tmr_r[i] <= '0;
            end else if (tmr_r[i] < dly_r) begin
                tmr_r[i] <= DLY_W'(tmr_r[i] + 1'b1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Element and collective outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_elem_alarm <= '0;
            o_elem_trip <= '0;
            o_trip_command_out <= '0;
            o_general_alarm <= 1'b0;
            o_general_trip <= 1'b0;
            o_phase_a_collective_alarm <= 1'b0;
            o_phase_b_collective_alarm <= 1'b0;
            o_phase_c_collective_alarm <= 1'b0;
            o_phase_a_collective_trip <= 1'b0;
            o_phase_b_collective_trip <= 1'b0;
            o_phase_c_collective_trip <= 1'b0;
            o_cb_a_trip <= 1'b0;
            o_cb_b_trip <= 1'b0;
        end else begin
            o_elem_alarm <= alarm_st;
            o_elem_trip <= trip_st;
            o_trip_command_out <= cmd_nxt;
            o_general_alarm <= |(alarm_st & contrib);
            o_general_trip <= |(trip_st & contrib);
            o_phase_a_collective_alarm <= |(alarm_st & contrib & onep_r & pha_r);
            o_phase_b_collective_alarm <= |(alarm_st & contrib & onep_r & phb_r);
            o_phase_c_collective_alarm <= |(alarm_st & contrib & onep_r & phc_r);
            o_phase_a_collective_trip <= |(trip_st & contrib & onep_r & pha_r);
            o_phase_b_collective_trip <= |(trip_st & contrib & onep_r & phb_r);
            o_phase_c_collective_trip <= |(trip_st & contrib & onep_r & phc_r);
            o_cb_a_trip <= |(cmd_nxt & cba_r);
            o_cb_b_trip <= |(cmd_nxt & cbb_r);
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_r <= PAT_CTRL_RST;
            supv_r <= '0;
            onep_r <= '0;
            dly_r <= DLY_W'(PAT_DLY_RST);
            cba_r <= '0;
            cbb_r <= '0;
            irq_mask_r <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                PAT_OFF_CTRL: ctrl_r <= i_pwdata[4:0];
                PAT_OFF_SUPV: supv_r <= i_pwdata[N_ELEM-1:0];
                PAT_OFF_ONEP: onep_r <= i_pwdata[N_ELEM-1:0];
                PAT_OFF_DLY: dly_r <= i_pwdata[DLY_W-1:0];
                PAT_OFF_MASK: irq_mask_r <= i_pwdata[PAT_IRQ_W-1:0];
                PAT_OFF_CBA: cba_r <= i_pwdata[N_ELEM-1:0];
                PAT_OFF_CBB: cbb_r <= i_pwdata[N_ELEM-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && (i_paddr > PAT_OFF_CBB || i_paddr[1:0] != 2'h0);
            if (rd_en) begin
                case (i_paddr)
                    PAT_OFF_CTRL: o_prdata <= {27'h0, ctrl_r};
                    PAT_OFF_SUPV: o_prdata <= pad(supv_r);
                    PAT_OFF_ONEP: o_prdata <= pad(onep_r);
                    PAT_OFF_DLY: o_prdata <= {16'h0, 16'(dly_r)};
                    PAT_OFF_STAT: o_prdata <= {23'h0, o_cb_b_trip, o_cb_a_trip,
                        o_phase_c_collective_trip, o_phase_b_collective_trip,
                        o_phase_a_collective_trip, o_general_trip, cmd_block,
                        prot_block, o_general_alarm};
                    PAT_OFF_ELEM: o_prdata <= pad(o_elem_trip);
                    PAT_OFF_IRQ: o_prdata <= {29'h0, irq_stat_r};
                    PAT_OFF_MASK: o_prdata <= {29'h0, irq_mask_r};
                    PAT_OFF_CBA: o_prdata <= pad(cba_r);
                    PAT_OFF_CBB: o_prdata <= pad(cbb_r);
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb begin
        irq_ev[0] = |(alarm_st & contrib) && !o_general_alarm;
        irq_ev[1] = |(trip_st & contrib) && !o_general_trip;
        irq_ev[2] = |cmd_nxt && !(|o_trip_command_out);
        irq_clr = (wr_en && i_paddr == PAT_OFF_IRQ) ? i_pwdata[PAT_IRQ_W-1:0] : '0;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            irq_stat_r <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
            o_irq <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_mask_r);
        end
    end
endmodule

// ---- test/pat_elem_model.sv ----
// Model of the protective elements facing the aggregator
// Assumes bench requests change just after a rising clock edge
`timescale 1ns/10ps
module pat_elem_model #(
    parameter int N_ELEM = 8
) (
    input wire logic i_clock,
    input wire logic [N_ELEM-1:0] i_req,
    input wire logic [N_ELEM-1:0] i_req_ph,
    output logic [N_ELEM-1:0] o_fault_crit,
    output logic [N_ELEM-1:0] o_fault_ph_a,
    output logic [N_ELEM-1:0] o_fault_ph_b,
    output logic [N_ELEM-1:0] o_fault_ph_c
);
    // Criterion and phase follow the request one edge later
    always_ff @(posedge i_clock) begin
        o_fault_crit <= i_req;
        o_fault_ph_a <= i_req & i_req_ph;
        o_fault_ph_b <= i_req & ~i_req_ph;
        o_fault_ph_c <= i_req & ~i_req_ph;
    end
endmodule

// ---- test/pat_aggregator_checker.sv ----
// Port checker for the aggregator
// Assumes it is bound onto pat_aggregator, one clock domain
`timescale 1ns/10ps
module pat_aggregator_checker #(
    parameter int N_ELEM = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [N_ELEM-1:0] i_fault_crit,
    input wire logic [N_ELEM-1:0] i_elem_cmd_block,
    input wire logic [N_ELEM-1:0] o_elem_alarm,
    input wire logic [N_ELEM-1:0] o_elem_trip,
    input wire logic [N_ELEM-1:0] o_trip_command_out,
    input wire logic o_general_alarm,
    input wire logic o_general_trip,
    input wire logic o_phase_a_collective_alarm,
    input wire logic o_phase_a_collective_trip,
    input wire logic o_cb_a_trip
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    property p_alarm_cause; (o_elem_alarm & ~$past(i_fault_crit, 2)) == '0; endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without cause");
    property p_trip_alarm; (o_elem_trip & ~o_elem_alarm) == '0; endproperty
    a_trip_alarm: assert property (p_trip_alarm) else $error("trip without alarm");
    property p_gen_alarm; o_general_alarm |-> o_elem_alarm != '0; endproperty
    a_gen_alarm: assert property (p_gen_alarm) else $error("general alarm alone");
    property p_gen_trip; o_general_trip |-> o_elem_trip != '0; endproperty
    a_gen_trip: assert property (p_gen_trip) else $error("general trip alone");
    property p_ph_alarm; o_phase_a_collective_alarm |-> o_general_alarm; endproperty
    a_ph_alarm: assert property (p_ph_alarm) else $error("phase alarm alone");
    property p_ph_trip; o_phase_a_collective_trip |-> o_general_trip; endproperty
    a_ph_trip: assert property (p_ph_trip) else $error("phase trip alone");
    property p_cmd; o_trip_command_out != '0 |-> (o_elem_trip | $past(o_elem_trip)) != '0;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command without trip");
    property p_cmd_blk; (i_elem_cmd_block == '1) [*3] |=> o_trip_command_out == '0; endproperty
    a_cmd_blk: assert property (p_cmd_blk) else $error("blocked command seen");
    property p_cb; o_cb_a_trip |-> (o_trip_command_out | $past(o_trip_command_out)) != '0;
    endproperty
    a_cb: assert property (p_cb) else $error("breaker trip without command");
    property p_ready; i_psel && !i_penable |=> o_pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_trip: cover property (o_general_trip);
    c_cmd: cover property (o_trip_command_out != '0);
    c_err: cover property (o_pslverr);
endmodule
bind pat_aggregator pat_aggregator_checker #(.N_ELEM(N_ELEM)) u_chk (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_fault_crit(i_fault_crit), .i_elem_cmd_block(i_elem_cmd_block),
    .o_elem_alarm(o_elem_alarm), .o_elem_trip(o_elem_trip),
    .o_trip_command_out(o_trip_command_out), .o_general_alarm(o_general_alarm),
    .o_general_trip(o_general_trip), .o_phase_a_collective_alarm(o_phase_a_collective_alarm),
    .o_phase_a_collective_trip(o_phase_a_collective_trip), .o_cb_a_trip(o_cb_a_trip));

// ---- test/tb_top.sv ----
// Self-checking bench for the aggregator
// Assumes the element model and checker compiled before it
`timescale 1ns/10ps
module tb_top;
    import pat_pkg::*;
    logic i_clock, i_rst_n, psel, penable, pwrite, pready, pslverr, err, eab, ebb, tcb;
    logic [7:0] paddr, req, req_ph, cblk, crit, ph_a, ph_b, ph_c, alarm, trip, cmd;
    logic [31:0] pwdata, prdata, rd;
    logic g_al, g_tr, pa_al, pb_al, pc_al, pa_tr, pb_tr, pc_tr, cba, cbb, irq;
    logic [11:0] tbl [9] = '{12'h142, 12'h24A, 12'h243, 12'h046, 12'h0E0, 12'h0D0, 12'h053,
        12'h000, 12'h440};
    int n_mismatch, total_checks;
    pat_elem_model u_elem (.i_clock(i_clock), .i_req(req), .i_req_ph(req_ph),
        .o_fault_crit(crit), .o_fault_ph_a(ph_a), .o_fault_ph_b(ph_b), .o_fault_ph_c(ph_c));
    pat_aggregator dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_fault_crit(crit),
        .i_fault_ph_a(ph_a), .i_fault_ph_b(ph_b), .i_fault_ph_c(ph_c),
        .i_ext_block_input_a(eab), .i_ext_block_input_b(ebb),
        .i_ext_trip_cmd_block_input(tcb), .i_elem_cmd_block(cblk), .o_elem_alarm(alarm),
        .o_elem_trip(trip), .o_trip_command_out(cmd), .o_general_alarm(g_al),
        .o_general_trip(g_tr), .o_phase_a_collective_alarm(pa_al),
        .o_phase_b_collective_alarm(pb_al), .o_phase_c_collective_alarm(pc_al),
        .o_phase_a_collective_trip(pa_tr), .o_phase_b_collective_trip(pb_tr),
        .o_phase_c_collective_trip(pc_tr), .o_cb_a_trip(cba), .o_cb_b_trip(cbb), .o_irq(irq));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge i_clock);
        if (i == 20) begin n_mismatch++; give_verdict; end
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0); chk(nm, rd, exp);
    endtask
    task settle;
        repeat (12) @(posedge i_clock);
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial begin
        i_rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; req = 8'h00; req_ph = 8'h00; cblk = 8'h00;
        eab = 1'b0; ebb = 1'b0; tcb = 1'b0; n_mismatch = 0; total_checks = 0;
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        rdchk("ctrl", PAT_OFF_CTRL, 32'h1); rdchk("dly", PAT_OFF_DLY, 32'h4);
        apb(1'b0, 8'h28, 32'h0); chk("slverr", err, 1'b1); chk("unmapped", rd, 32'h0);
        apb(1'b1, PAT_OFF_DLY, 32'h2); apb(1'b1, PAT_OFF_ONEP, 32'hFF);
        apb(1'b1, PAT_OFF_CBA, 32'h1); apb(1'b1, PAT_OFF_MASK, 32'h7);
        req <= 8'h01;
        repeat (2) @(posedge i_clock);
        req <= 8'h00;
        settle;
        rdchk("short fault irq", PAT_OFF_IRQ, 32'h1);
        apb(1'b1, PAT_OFF_IRQ, 32'h7);
        req <= 8'h01; req_ph <= 8'h01;
        settle;
        chk("alarm", {alarm, g_al, pa_al, pb_al}, {8'h01, 3'b110});
        chk("trip", {trip, g_tr, pa_tr, pb_tr}, {8'h01, 3'b110});
        chk("cmd", {cmd, cba, cbb}, {8'h01, 2'b10});
        rdchk("elem", PAT_OFF_ELEM, 32'h1);
        rdchk("irq status", PAT_OFF_IRQ, 32'h7); chk("irq", irq, 1'b1);
        apb(1'b1, PAT_OFF_IRQ, 32'h7); rdchk("irq clr", PAT_OFF_IRQ, 32'h0); chk("irq", irq, 1'b0);
        foreach (tbl[k]) begin
            apb(1'b1, PAT_OFF_CTRL, {27'h0, tbl[k][10:6]});
            eab <= tbl[k][5]; ebb <= tbl[k][4]; tcb <= tbl[k][3]; cblk <= {8{tbl[k][2]}};
            settle;
            chk("blk alarm", {alarm, g_al}, {7'h0, tbl[k][1], tbl[k][1]});
            chk("blk cmd", cmd, {7'h0, tbl[k][0]});
        end
        apb(1'b1, PAT_OFF_CTRL, 32'h1);
        eab <= 1'b0; ebb <= 1'b0; tcb <= 1'b0; cblk <= 8'h00;
        apb(1'b1, PAT_OFF_SUPV, 32'h2); apb(1'b1, PAT_OFF_ONEP, 32'hFE);
        req <= 8'h03; req_ph <= 8'h03;
        settle;
        chk("supv states", {alarm, trip}, 16'h0303);
        chk("supv cmd", cmd, 8'h01);
        chk("supv phase", {g_al, g_tr, pa_al, pa_tr}, 4'hC);
        apb(1'b1, PAT_OFF_ONEP, 32'hFF); apb(1'b1, PAT_OFF_CBB, 32'h1);
        req_ph <= 8'h00;
        settle;
        chk("phase bc", {pb_al, pc_al, pb_tr, pc_tr, pa_al, cbb}, 6'h3D);
        rdchk("stat", PAT_OFF_STAT, 32'h1E9);
        apb(1'b1, PAT_OFF_MASK, 32'h0);
        @(posedge i_clock);
        chk("masked irq", irq, 1'b0);
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        give_verdict;
    end
endmodule
